// ==== hw/ccs_regs.sv ====
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "ccs_defines.svh"

// What this block does
// (R1) Six general registers plus five sixteen-register pages in one window.
// (R2) Page field maps diagnosis, buffers 1-3 or filters; 5-7 reserved.
// (R3) Receive flag per buffer sets on good store; clears by write or ready.
// (R4) Transmit flag sets on success, or on arbitration won in early mode.
// (R5) Status flag sets on standby dominant, passive or bus-off, rx errors.
// (R6) Overrun flag sets when an accepted message finds no free buffer.
// (R7) Transmit-error flag sets on an error while sending.
// (R8) Error-pending reads high while status, overrun or tx-error flag set.
// (R9) Writing 0 to a flag bit clears it; writing 1 leaves it.
// (R10) Interrupt requests are gated by their matching enable bits.
// (R11) Status enable requests interrupt on status change or standby wake.
// (R12) Early mode moves transmit interrupt to arbitration won.
// (R13) Unused high bits read zero and ignore writes.
// (R14) Bus-off sets when error count passes 255, clears on rejoining.
// (R15) Error-passive bit shows passive state, low when active or bus-off.
// (R16) Self-reception lets own filtered messages be received, else discard.
// (R17) No-retry bit stops retransmission of failed messages.
// (R18) Leaving standby waits 11 recessive bits, or 128 such sequences.
// (R19) Wake-pulse bit drives a dominant pulse when leaving standby.
// (R20) Clearing run enters standby after transfers; reads 1 until there.
// (R21) Quantum is clock times divider plus one; jump width plus one.
// (R22) Segments last field plus one quanta; timing resets to 23h.
// (R23) Prescaler and timing writes act only in standby.
// (R24) Prescaler and timing writes outside standby are ignored.
// (R25) Setting run leaves standby via wake pulse or straight to resync.

module ccs_regs (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire ccs_pkg::ccs_core_evt_s core_evt,
  input  wire logic                  bus_rx,
  input  wire logic [7:0]            win_rdata,
  output ccs_pkg::ccs_win_s          win,
  output ccs_pkg::ccs_cfg_s          cfg,
  output logic      [2:0]            rx_release,
  output logic                       bus_tx_dominant,
  output logic                       irq
);

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  function automatic ccs_pkg::ccs_reg_e decode(input logic [7:0] a);
    if (a[1:0] != 2'b00) begin
      decode = ccs_pkg::CCS_R_NONE;
    end else if (a == `CCS_ADDR_FLAGS) begin
      decode = ccs_pkg::CCS_R_FLAGS;
    end else if (a == `CCS_ADDR_ENABLE) begin
      decode = ccs_pkg::CCS_R_ENABLE;
    end else if (a == `CCS_ADDR_CTRL) begin
      decode = ccs_pkg::CCS_R_CTRL;
    end else if (a == `CCS_ADDR_PRESC) begin
      decode = ccs_pkg::CCS_R_PRESC;
    end else if (a == `CCS_ADDR_SEGS) begin
      decode = ccs_pkg::CCS_R_SEGS;
    end else if (a == `CCS_ADDR_PAGE) begin
      decode = ccs_pkg::CCS_R_PAGE;
    end else if (a[7:2] >= `CCS_WIN_LO_IDX &&
                 a[7:2] <= `CCS_WIN_HI_IDX) begin
      decode = ccs_pkg::CCS_R_WIN;
    end else begin
      decode = ccs_pkg::CCS_R_NONE;
    end
  endfunction

  ccs_pkg::ccs_mode_e mode_reg;
  ccs_pkg::ccs_reg_e  sel;
  logic [7:1] flags_reg;
  logic [7:1] flags_next;
  logic [7:1] flag_set;
  logic [6:0] enable_reg;
  logic [4:0] ctrl_reg;
  logic [7:0] presc_reg;
  logic [6:0] segs_reg;
  logic [2:0] page_reg;
  logic       bus_off_reg;
  logic       passive_prev_reg;
  logic       bus_off_prev_reg;
  logic [3:0] run_cnt_reg;
  logic [6:0] seq_cnt_reg;
  logic       sample_tick;
  logic       bit_tick;
  logic       setup;
  logic       wr;
  logic       page_ok;
  logic       standby;
  logic       passive;
  logic       error_pending;
  logic       run_readback;
  logic       seq_done;
  logic       resync_done;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Zero wait states: read data is captured in the setup cycle, so the
  // access phase can always complete at once.
  assign sel     = decode(paddr);
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (sel == ccs_pkg::CCS_R_NONE);
  assign standby = (mode_reg == ccs_pkg::CCS_STANDBY);
  assign page_ok = (page_reg <= `CCS_PAGE_LAST); // [R2]

  // Reserved pages are neither forwarded nor readable.
  assign win.access    = psel && (sel == ccs_pkg::CCS_R_WIN) &&
                         page_ok; // [R1]
  assign win.wr_strobe = win.access && penable && pwrite;
  assign win.page      = page_reg; // [R2]
  assign win.index     = paddr[5:2];
  assign win.wdata     = pwdata[7:0];

  always_comb begin
    rd_byte = 8'h00;
    if (sel == ccs_pkg::CCS_R_FLAGS) begin
      rd_byte = {flags_reg, error_pending};
    end else if (sel == ccs_pkg::CCS_R_ENABLE) begin
      rd_byte = {1'b0, enable_reg}; // [R13]
    end else if (sel == ccs_pkg::CCS_R_CTRL) begin
      rd_byte = {1'b0, bus_off_reg, passive, ctrl_reg[4:1], run_readback};
    end else if (sel == ccs_pkg::CCS_R_PRESC) begin
      rd_byte = presc_reg;
    end else if (sel == ccs_pkg::CCS_R_SEGS) begin
      rd_byte = {1'b0, segs_reg}; // [R13]
    end else if (sel == ccs_pkg::CCS_R_PAGE) begin
      rd_byte = {5'h00, page_reg}; // [R13]
    end else if (sel == ccs_pkg::CCS_R_WIN && page_ok) begin
      rd_byte = win_rdata; // [R1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  assign passive = core_evt.err_passive && !bus_off_reg; // [R15]
  assign error_pending = flags_reg[`CCS_F_SC] || flags_reg[`CCS_F_OR] ||
                         flags_reg[`CCS_F_TE]; // [R8]

  always_comb begin
    flag_set = 7'h00;
    flag_set[`CCS_F_RX3:`CCS_F_RX1] = core_evt.rx_stored; // [R3]
    flag_set[`CCS_F_TX] = enable_reg[`CCS_E_EARLY] ?
                          core_evt.tx_arb_won :
                          core_evt.tx_success; // [R4] [R12]
    flag_set[`CCS_F_SC] =
      (standby && !bus_rx) ||
      (mode_reg == ccs_pkg::CCS_ACTIVE &&
       ((passive && !passive_prev_reg) ||
        (bus_off_reg && !bus_off_prev_reg))) ||
      (enable_reg[`CCS_E_ESR] && core_evt.rx_error); // [R5]
    flag_set[`CCS_F_OR] = core_evt.overrun; // [R6]
    flag_set[`CCS_F_TE] = core_evt.tx_error; // [R7]
  end

  // An event in the cycle of a clear is kept: the set is applied last.
  always_comb begin
    flags_next = flags_reg;
    if (wr && sel == ccs_pkg::CCS_R_FLAGS) begin
      flags_next = flags_reg & pwdata[7:1]; // [R9]
    end
    flags_next[`CCS_F_RX3:`CCS_F_RX1] = flags_next[`CCS_F_RX3:`CCS_F_RX1] &
                                        ~core_evt.rdy_cleared; // [R3]
    flags_next = flags_next | flag_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= `CCS_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // A software clear of a receive flag hands the buffer back to the core.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_release
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_release[gi] <= 1'b0;
        end else begin
          rx_release[gi] <= wr && (sel == ccs_pkg::CCS_R_FLAGS) &&
                            flags_reg[`CCS_F_RX1 + gi] &&
                            !pwdata[`CCS_F_RX1 + gi]; // [R3]
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(flags_reg[`CCS_F_RX3:`CCS_F_RX1]) &&
              enable_reg[`CCS_E_RX]) ||
             (flags_reg[`CCS_F_TX] && enable_reg[`CCS_E_TX]) ||
             (flags_reg[`CCS_F_SC] && enable_reg[`CCS_E_SC]) ||
             (flags_reg[`CCS_F_OR] && enable_reg[`CCS_E_OR]) ||
             (flags_reg[`CCS_F_TE] && enable_reg[`CCS_E_TE]); // [R10] [R11]
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `CCS_EN_RST;
    end else if (wr && sel == ccs_pkg::CCS_R_ENABLE) begin
      enable_reg <= pwdata[6:0]; // [R13]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CCS_CTRL_RST;
    end else if (wr && sel == ccs_pkg::CCS_R_CTRL) begin
      ctrl_reg <= pwdata[4:0]; // [R13]
    end
  end

  // Changing bit timing while on the bus would corrupt frames.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= `CCS_PRESC_RST;
      segs_reg  <= `CCS_SEGS_RST; // [R22]
    end else if (wr && standby) begin // [R23] [R24]
      if (sel == ccs_pkg::CCS_R_PRESC) begin
        presc_reg <= pwdata[7:0];
      end
      if (sel == ccs_pkg::CCS_R_SEGS) begin
        segs_reg <= pwdata[6:0]; // [R13]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_reg <= `CCS_PAGE_RST;
    end else if (wr && sel == ccs_pkg::CCS_R_PAGE) begin
      page_reg <= pwdata[2:0]; // [R2] [R13]
    end
  end

  assign cfg.self_reception  = ctrl_reg[`CCS_C_SELF]; // [R16]
  assign cfg.no_retry        = ctrl_reg[`CCS_C_NORTY]; // [R17]
  assign cfg.early_transmit  = enable_reg[`CCS_E_EARLY]; // [R12]
  assign cfg.quantum_divider = presc_reg[5:0]; // [R21]
  assign cfg.jump_width      = presc_reg[7:6]; // [R21]
  assign cfg.segment_one_len = segs_reg[3:0]; // [R22]
  assign cfg.segment_two_len = segs_reg[6:4]; // [R22]
  assign cfg.node_running    = (mode_reg == ccs_pkg::CCS_ACTIVE);

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // The prescaler stops in standby to save power.
  ccs_quanta u_quanta (
    .pclk            (pclk),
    .presetn         (presetn),
    .enable          (!standby),
    .quantum_divider (presc_reg[5:0]),
    .segment_one_len (segs_reg[3:0]),
    .segment_two_len (segs_reg[6:4]),
    .sample_tick     (sample_tick),
    .bit_tick        (bit_tick)
  );

  // ----------------------------------------------------------------
  // Node state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      passive_prev_reg <= 1'b0;
      bus_off_prev_reg <= 1'b0;
    end else begin
      passive_prev_reg <= passive;
      bus_off_prev_reg <= bus_off_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_off_reg <= 1'b0;
    end else if (core_evt.tx_err_count[8]) begin
      bus_off_reg <= 1'b1; // [R14]
    end else if (resync_done) begin
      bus_off_reg <= 1'b0; // [R14]
    end
  end

  // ----------------------------------------------------------------
  // Resynchronisation counters
  // ----------------------------------------------------------------
  assign seq_done = sample_tick && bus_rx &&
                    (run_cnt_reg == `CCS_RESYNC_BITS - 4'd1);
  assign resync_done = (mode_reg == ccs_pkg::CCS_RESYNC) && seq_done &&
                       ((ctrl_reg[`CCS_C_FAST] && !bus_off_reg) ||
                        seq_cnt_reg == `CCS_RESYNC_SEQS); // [R18]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt_reg <= 4'h0;
      seq_cnt_reg <= 7'h00;
    end else if (mode_reg != ccs_pkg::CCS_RESYNC) begin
      run_cnt_reg <= 4'h0;
      seq_cnt_reg <= 7'h00;
    end else if (sample_tick) begin
      if (!bus_rx || seq_done) begin
        run_cnt_reg <= 4'h0; // [R18]
      end else begin
        run_cnt_reg <= run_cnt_reg + 4'h1;
      end
      if (seq_done) begin
        seq_cnt_reg <= seq_cnt_reg + 7'h01; // [R18]
      end
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  assign run_readback = !standby; // [R20]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg        <= ccs_pkg::CCS_STANDBY;
      bus_tx_dominant <= 1'b0;
    end else begin
      case (mode_reg)
        ccs_pkg::CCS_STANDBY: begin
          if (ctrl_reg[`CCS_C_RUN]) begin
            if (ctrl_reg[`CCS_C_WAKE]) begin
              mode_reg        <= ccs_pkg::CCS_WAKE; // [R25]
              bus_tx_dominant <= 1'b1; // [R19]
            end else begin
              mode_reg <= ccs_pkg::CCS_RESYNC; // [R25]
            end
          end
        end
        ccs_pkg::CCS_WAKE: begin
          if (bit_tick) begin
            mode_reg        <= ccs_pkg::CCS_RESYNC; // [R19]
            bus_tx_dominant <= 1'b0;
          end
        end
        ccs_pkg::CCS_RESYNC: begin
          if (!ctrl_reg[`CCS_C_RUN]) begin
            mode_reg <= ccs_pkg::CCS_STANDBY;
          end else if (resync_done) begin
            mode_reg <= ccs_pkg::CCS_ACTIVE; // [R18]
          end
        end
        ccs_pkg::CCS_ACTIVE: begin
          if (!ctrl_reg[`CCS_C_RUN] && !core_evt.transfer_busy) begin
            mode_reg <= ccs_pkg::CCS_STANDBY; // [R20]
          end else if (bus_off_reg) begin
            mode_reg <= ccs_pkg::CCS_RESYNC; // [R14]
          end
        end
        default: begin
          mode_reg        <= ccs_pkg::CCS_STANDBY;
          bus_tx_dominant <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== hw/ccs_defines.svh ====
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CCS_ADDR_FLAGS  8'h00
`define CCS_ADDR_ENABLE 8'h04
`define CCS_ADDR_CTRL   8'h08
`define CCS_ADDR_PRESC  8'h0c
`define CCS_ADDR_SEGS   8'h10
`define CCS_ADDR_PAGE   8'h14
`define CCS_WIN_LO_IDX  6'h10
`define CCS_WIN_HI_IDX  6'h1f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCS_F_RX3   7
`define CCS_F_RX1   5
`define CCS_F_TX    4
`define CCS_F_SC    3
`define CCS_F_OR    2
`define CCS_F_TE    1
`define CCS_E_ESR   6
`define CCS_E_RX    5
`define CCS_E_TX    4
`define CCS_E_SC    3
`define CCS_E_OR    2
`define CCS_E_TE    1
`define CCS_E_EARLY 0
`define CCS_C_SELF  4
`define CCS_C_NORTY 3
`define CCS_C_FAST  2
`define CCS_C_WAKE  1
`define CCS_C_RUN   0

// ----------------------------------------------------------------
// Reset values, masks and counts
// ----------------------------------------------------------------
`define CCS_FLAGS_RST 7'h00
`define CCS_EN_RST    7'h00
`define CCS_CTRL_RST  5'h00
`define CCS_PRESC_RST 8'h00
`define CCS_SEGS_RST  7'h23
`define CCS_PAGE_RST  3'h0
`define CCS_PAGE_LAST 3'h4
`define CCS_RESYNC_BITS 4'd11
`define CCS_RESYNC_SEQS 7'd127

`endif

// ==== hw/ccs_pkg.sv ====
package ccs_pkg;

  typedef enum logic [1:0] {
    CCS_STANDBY,
    CCS_WAKE,
    CCS_RESYNC,
    CCS_ACTIVE
  } ccs_mode_e;

  typedef enum logic [2:0] {
    CCS_R_FLAGS,
    CCS_R_ENABLE,
    CCS_R_CTRL,
    CCS_R_PRESC,
    CCS_R_SEGS,
    CCS_R_PAGE,
    CCS_R_WIN,
    CCS_R_NONE
  } ccs_reg_e;

  typedef struct packed {
    logic [2:0] rx_stored;
    logic [2:0] rdy_cleared;
    logic       tx_arb_won;
    logic       tx_success;
    logic       tx_error;
    logic       rx_error;
    logic       overrun;
    logic       err_passive;
    logic [8:0] tx_err_count;
    logic       transfer_busy;
  } ccs_core_evt_s;

  typedef struct packed {
    logic       self_reception;
    logic       no_retry;
    logic       early_transmit;
    logic [5:0] quantum_divider;
    logic [1:0] jump_width;
    logic [3:0] segment_one_len;
    logic [2:0] segment_two_len;
    logic       node_running;
  } ccs_cfg_s;

  typedef struct packed {
    logic       access;
    logic       wr_strobe;
    logic [2:0] page;
    logic [3:0] index;
    logic [7:0] wdata;
  } ccs_win_s;

endpackage

// ==== hw/ccs_quanta.sv ====
`timescale 1ns/10ps
`include "ccs_defines.svh"

module ccs_quanta (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic [5:0] quantum_divider,
  input  wire logic [3:0] segment_one_len,
  input  wire logic [2:0] segment_two_len,
  output logic            sample_tick,
  output logic            bit_tick
);

  logic [5:0] pre_cnt_reg;
  logic [4:0] q_cnt_reg;
  logic       q_tick;
  logic [4:0] q_last;
  logic [4:0] q_sample;

  // ----------------------------------------------------------------
  // Quantum and bit timing
  // ----------------------------------------------------------------
  assign q_tick   = enable && (pre_cnt_reg == quantum_divider); // [R21]
  assign q_last   = {1'b0, segment_one_len} + {2'b00, segment_two_len}
                    + 5'd2; // [R22]
  assign q_sample = {1'b0, segment_one_len} + 5'd1; // [R22]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= 6'h00;
    end else if (!enable || q_tick) begin
      pre_cnt_reg <= 6'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_cnt_reg <= 5'h00;
    end else if (!enable) begin
      q_cnt_reg <= 5'h00;
    end else if (q_tick) begin
      q_cnt_reg <= (q_cnt_reg == q_last) ? 5'h00 : q_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else begin
      sample_tick <= q_tick && (q_cnt_reg == q_sample);
      bit_tick    <= q_tick && (q_cnt_reg == q_last);
    end
  end

endmodule

// ==== dv/ccs_checker.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port checks for the control and status registers.
// ----------------------------------------------------------------
module ccs_checker (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire ccs_pkg::ccs_win_s win,
  input wire ccs_pkg::ccs_cfg_s cfg,
  input wire logic [2:0]        rx_release,
  input wire logic              bus_tx_dominant
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bad;
  logic wrf;
  // Holes between the general block and the window, and past it.
  assign bad = paddr[1:0] != 2'h0 || (paddr > 8'h14 && paddr < 8'h40)
               || paddr > 8'h7c;
  assign wrf = psel && penable && pwrite && paddr == 8'h00;
  slverr_map_a: assert property (psel && penable |-> pslverr == bad)
    else $error("pslverr does not match the address map");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside an access phase");
  prdata_hi_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  win_index_a: assert property (
      win.access |-> paddr[7:6] == 2'h1 && win.index == paddr[5:2])
    else $error("window access with wrong index");
  win_strobe_a: assert property (
      win.wr_strobe |-> win.access && penable && pwrite &&
      win.wdata == pwdata[7:0])
    else $error("window write strobe without a write");
  cfg_frozen_a: assert property (
      cfg.node_running |=> $stable({cfg.quantum_divider, cfg.jump_width,
      cfg.segment_one_len, cfg.segment_two_len}))
    else $error("timing changed while running");
  wake_idle_a: assert property (bus_tx_dominant |-> !cfg.node_running)
    else $error("wake pulse while running");
  rx_release_a: assert property (
      rx_release != 3'h0 |-> $past(wrf))
    else $error("buffer release without a flag write");
endmodule

bind ccs_regs ccs_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .win(win),
  .cfg(cfg), .rx_release(rx_release), .bus_tx_dominant(bus_tx_dominant));

// ==== dv/ccs_bus_node.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Other nodes on the bus: a wired-AND line that idles recessive.
// ----------------------------------------------------------------
module ccs_bus_node (
  input  wire logic bus_tx_dominant,
  input  wire logic wake_req,
  output logic      bus_rx
);
  // Any node driving dominant wins, so the pulse is seen on our own input.
  assign bus_rx = !(bus_tx_dominant || wake_req);
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Register block bench.
// ----------------------------------------------------------------
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, wake_req = 1'b0, saw_wake = 1'b0;
  logic                   pready, pslverr, irq, bus_rx, bus_tx_dominant;
  logic [7:0]             paddr = 8'h00, win_rdata = 8'h00, f;
  logic [31:0]            pwdata = 32'h0, seed = 32'hdecc0303;
  logic [31:0]            prdata;
  logic [32:0]            r;
  logic [2:0]             rx_release;
  ccs_pkg::ccs_core_evt_s ev = '0;
  ccs_pkg::ccs_win_s      win;
  ccs_pkg::ccs_cfg_s      cfg;
  int                     error_cnt = 0, check_count = 0, i;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (bus_tx_dominant) saw_wake <= 1'b1;

  ccs_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_evt(ev),
    .bus_rx(bus_rx), .win_rdata(win_rdata), .win(win), .cfg(cfg),
    .rx_release(rx_release), .bus_tx_dominant(bus_tx_dominant), .irq(irq));
  ccs_bus_node u_bus (.bus_tx_dominant(bus_tx_dominant),
    .wake_req(wake_req), .bus_rx(bus_rx));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Event word: rx stored, ready cleared, arb, ok, tx err, rx err, ovr.
  function automatic logic [7:0] expf(input logic [6:0] e,
                                      input logic [10:0] p);
    logic sc;
    sc = p[1] & e[6];
    return {p[10:8], (e[0] ? p[4] : p[3]), sc, p[0], p[2],
            sc | p[0] | p[2]};
  endfunction
  function automatic logic expi(input logic [6:0] e, input logic [7:0] x);
    return (|x[7:5] & e[5]) | (|(x[4:1] & e[4:1]));
  endfunction
  task automatic chk(input string n, input logic [32:0] x,
                     input logic [32:0] g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x,
                    input string n);
    apb(1'b0, a, 8'h00);
    chk(n, {25'h0, x}, r);
  endtask
  task automatic pulse(input logic [10:0] p);
    @(posedge pclk);
    ev[21:11] <= p;
    @(posedge pclk);
    ev[21:11] <= 11'h0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic waitrun(input int n);
    int k;
    for (k = 0; k < n && cfg.node_running !== 1'b1; k++) @(posedge pclk);
  endtask
  task results;
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // The slowest path is 128 sequences of eleven 8-clock bits.
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    results;
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(8'(4 * i), i == 4 ? 8'h23 : 8'h00, "reset");
    end
    apb(1'b1, 8'h14, 8'hff);
    rd(8'h14, 8'h07, "page");
    apb(1'b1, 8'h10, 8'hff);
    rd(8'h10, 8'h7f, "segments");
    chk("seg one", 33'd15, 33'(cfg.segment_one_len));
    chk("seg two", 33'd7, 33'(cfg.segment_two_len));
    apb(1'b1, 8'h10, 8'h23);
    apb(1'b1, 8'h0c, 8'hc0);
    rd(8'h0c, 8'hc0, "prescaler");
    chk("jump", 33'd3, 33'(cfg.jump_width));
    win_rdata <= seed[7:0];
    apb(1'b1, 8'h14, 8'h01);
    rd(8'h44, seed[7:0], "window");
    apb(1'b1, 8'h48, seed[15:8]);
    chk("page out", 33'h1, 33'(win.page));
    apb(1'b1, 8'h14, 8'h05);
    rd(8'h44, 8'h00, "reserved page");
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped", {1'b1, 32'h0}, r);
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      apb(1'b1, 8'h04, {1'b0, seed[6:0]});
      rd(8'h04, {1'b0, seed[6:0]}, "enables");
      chk("early", 33'(seed[0]), 33'(cfg.early_transmit));
      pulse({seed[10:8], 3'h0, seed[15:11]});
      f = expf(seed[6:0], {seed[10:8], 3'h0, seed[15:11]});
      rd(8'h00, f, "flags");
      chk("irq", 33'(expi(seed[6:0], f)), 33'(irq));
      apb(1'b1, 8'h00, ~f);
      rd(8'h00, 8'h00, "cleared");
    end
    pulse(11'h700);
    pulse(11'h040);
    rd(8'h00, 8'ha0, "ready cleared");
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h04, 8'h08);
    wake_req <= 1'b1;
    repeat (2) @(posedge pclk);
    wake_req <= 1'b0;
    rd(8'h00, 8'h09, "standby dominant");
    chk("wake irq", 33'h1, 33'(irq));
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h08, 8'h1f);
    waitrun(300);
    chk("fast start", 33'h1, 33'(cfg.node_running));
    chk("wake pulse", 33'h1, 33'(saw_wake));
    chk("self rx", 33'h1, 33'(cfg.self_reception));
    chk("no retry", 33'h1, 33'(cfg.no_retry));
    apb(1'b1, 8'h0c, 8'h3f);
    rd(8'h0c, 8'hc0, "frozen");
    ev.err_passive <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(8'h00, 8'h09, "passive flag");
    rd(8'h08, 8'h3f, "passive");
    apb(1'b1, 8'h00, 8'hf6);
    ev.transfer_busy <= 1'b1;
    apb(1'b1, 8'h08, 8'h06);
    rd(8'h08, 8'h27, "run held");
    chk("retry on", 33'h0, 33'(cfg.no_retry));
    ev.transfer_busy <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(8'h08, 8'h26, "standby");
    ev.err_passive <= 1'b0;
    apb(1'b1, 8'h08, 8'h01);
    repeat (2000) @(posedge pclk);
    chk("slow wait", 33'h0, 33'(cfg.node_running));
    waitrun(12000);
    chk("slow start", 33'h1, 33'(cfg.node_running));
    ev.tx_err_count <= 9'h100;
    repeat (4) @(posedge pclk);
    rd(8'h08, 8'h41, "bus off");
    chk("bus off halt", 33'h0, 33'(cfg.node_running));
    results;
  end
endmodule
